// file: include/eitz_pkg.sv
// Package: register map, field positions, reset values and timing counts
package eitz_pkg;

  // ************************************************************
  // Register word addresses (byte offsets on APB)
  // ************************************************************
  localparam logic [11:0] EITZ_ADDR_MAIN = 12'h000;   // Main irq control
  localparam logic [11:0] EITZ_ADDR_SECOND = 12'h004; // Second irq control
  localparam logic [11:0] EITZ_ADDR_THIRD = 12'h008;  // Third irq control
  localparam logic [11:0] EITZ_ADDR_PCE = 12'h00c;    // Pin change enable
  localparam logic [11:0] EITZ_ADDR_TCTL = 12'h010;   // Timer control
  localparam logic [11:0] EITZ_ADDR_TLOW = 12'h014;   // Count low byte
  localparam logic [11:0] EITZ_ADDR_THIGH = 12'h018;  // Count high buffer
  localparam logic [11:0] EITZ_ADDR_PWR = 12'h01c;    // Power mode / wake

  // ************************************************************
  // Main irq control fields
  // ************************************************************
  localparam int EITZ_MAIN_GIE = 7;       // Global irq enable
  localparam int EITZ_MAIN_TOIE = 5;      // Timer overflow enable
  localparam int EITZ_MAIN_E0IE = 4;      // Ext zero enable
  localparam int EITZ_MAIN_PCIE = 3;      // Port change enable
  localparam int EITZ_MAIN_TOIF = 2;      // Timer overflow flag
  localparam int EITZ_MAIN_E0IF = 1;      // Ext zero flag
  localparam int EITZ_MAIN_PCIF = 0;      // Port change flag

  // ************************************************************
  // Second irq control fields
  // ************************************************************
  localparam int EITZ_SEC_POL0 = 6;       // Polarity bits 6..3 for pins 0..3
  localparam int EITZ_SEC_TOIP = 2;       // Timer overflow priority
  localparam int EITZ_SEC_E3IP = 1;       // Ext three priority
  localparam int EITZ_SEC_PCIP = 0;       // Port change priority

  // ************************************************************
  // Third irq control fields
  // ************************************************************
  localparam int EITZ_THR_E2IP = 7;       // Ext two priority
  localparam int EITZ_THR_E1IP = 6;       // Ext one priority
  localparam int EITZ_THR_IE1 = 3;        // Enables 3..5 for pins 1..3
  localparam int EITZ_THR_IF1 = 0;        // Flags 0..2 for pins 1..3

  // ************************************************************
  // Timer control fields
  // ************************************************************
  localparam int EITZ_TCTL_ON = 7;        // Timer run
  localparam int EITZ_TCTL_8BIT = 6;      // 1 = 8-bit mode
  localparam int EITZ_TCTL_SRC = 5;       // Source select
  localparam int EITZ_TCTL_EDGE = 4;      // Counter edge select

  // ************************************************************
  // Reset values and masks
  // ************************************************************
  localparam logic [7:0] EITZ_RST_MAIN = 8'h00;
  localparam logic [7:0] EITZ_RST_SECOND = 8'hff;
  localparam logic [7:0] EITZ_RST_THIRD = 8'hc0;
  localparam logic [7:0] EITZ_RST_PCE = 8'h00;
  localparam logic [7:0] EITZ_RST_TCTL = 8'hff;
  localparam logic [7:0] EITZ_PCE_MASK = 8'hf0;   // Bits 3..0 read zero

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int EITZ_CLK_HZ = 50000000;          // System clock
  localparam int EITZ_CLK_PER_INSTR = 4;          // Clocks per instruction cycle
  localparam int EITZ_WR_INHIBIT_INSTR = 2;       // Instr cycles held after write
  localparam logic [3:0] EITZ_WR_INHIBIT_CLKS = 4'(EITZ_WR_INHIBIT_INSTR * EITZ_CLK_PER_INSTR);

  // Synchronised input bundle
  typedef struct packed {
    logic [3:0] ext;    // Ext irq pins
    logic [3:0] port;   // Port b pins 7..4
    logic cnt;          // Counter clock pin
  } eitz_pins_type;

endpackage

// file: src/eitz_top.sv
// Edge interrupts, port change interrupt and timer zero behind an APB slave
//
// Contract
// (RL1) Ext pin edge polarity: 1 rising, 0 falling
// (RL2) Valid edge sets flag; enable masks it
// (RL3) Software clears flag before re-enabling
// (RL4) Enabled ext irq wakes from power mode
// (RL5) Vector after wake only if global enabled
// (RL6) Ext one/two/three priority bits fixed positions
// (RL7) Ext zero always high priority
// (RL8) 8-bit overflow FFh to 00h sets flag
// (RL9) 16-bit overflow FFFFh to 0000h sets flag
// (RL10) Overflow irq enable and priority bits
// (RL11) Port pins 7..4 change sets flag
// (RL12) Port change needs common and pin enable
// (RL13) Port change priority from its bit
// (RL14) Pin enable bits 7..4; 3..0 read zero
// (RL15) Source 0 counts every internal clock
// (RL16) Count write inhibits two instruction cycles
// (RL17) Source 1 counts pin edges, select edge
// (RL18) Counter pin synchronised before counting
// (RL19) Low read latches true high byte
// (RL20) Low write loads high from buffer
// (RL21) Pins pass two-stage synchroniser
// (RL22) Change compares level with previous cycle
`timescale 1ns/10ps
`default_nettype none
module eitz_top
  import eitz_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // External pins
  input wire logic [3:0] EXT_IRQ_PIN_I,
  input wire logic [3:0] PORT_B_PINS_I,
  input wire logic COUNTER_CLOCK_PIN_I,
  // Processor side
  output logic IRQ_HIGH_O,
  output logic IRQ_LOW_O,
  output logic WAKE_O
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] main_q;            // Main irq control
  logic [7:0] second_q;          // Second irq control
  logic [7:0] third_q;           // Third irq control
  logic [7:0] pce_q;             // Pin change enable
  logic [7:0] tctl_q;            // Timer control
  logic [7:0] high_buf_q;        // Count high buffer
  logic [15:0] count_q;          // True count
  logic [3:0] inhibit_q;         // Write inhibit counter
  logic sleep_q;                 // Power managed mode
  logic [3:0] wake_en_q;         // Enables captured at sleep entry
  logic wake_q;                  // Wake pulse
  logic [31:0] prdata_q;         // Read data
  eitz_pins_type sync1_q;        // First sync stage
  eitz_pins_type sync2_q;        // Second sync stage
  eitz_pins_type prev_q;         // Previous synced level

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic acc;                     // Access phase
  logic wr;                      // Write strobe
  logic rd;                      // Read strobe
  logic mapped;                  // Address hits a register
  assign acc = PSEL_I & PENABLE_I;
  assign wr = acc & PWRITE_I;
  assign rd = acc & ~PWRITE_I;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc & ~mapped;
  assign PRDATA_O = prdata_q;

  // Address hit helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  assign mapped = hit(PADDR_I, EITZ_ADDR_MAIN) | hit(PADDR_I, EITZ_ADDR_SECOND) |
                  hit(PADDR_I, EITZ_ADDR_THIRD) | hit(PADDR_I, EITZ_ADDR_PCE) |
                  hit(PADDR_I, EITZ_ADDR_TCTL) | hit(PADDR_I, EITZ_ADDR_TLOW) |
                  hit(PADDR_I, EITZ_ADDR_THIGH) | hit(PADDR_I, EITZ_ADDR_PWR);

  logic wr_main, wr_third, wr_low, rd_low; // Register strobes
  assign wr_main = wr & hit(PADDR_I, EITZ_ADDR_MAIN);
  assign wr_third = wr & hit(PADDR_I, EITZ_ADDR_THIRD);
  assign wr_low = wr & hit(PADDR_I, EITZ_ADDR_TLOW);
  assign rd_low = rd & hit(PADDR_I, EITZ_ADDR_TLOW);

  // ************************************************************
  // Input synchroniser
  // ************************************************************
  eitz_pins_type pins_raw;       // Raw pin bundle
  assign pins_raw = '{ext: EXT_IRQ_PIN_I, port: PORT_B_PINS_I, cnt: COUNTER_CLOCK_PIN_I};

  // Two stages, then a history stage for edges
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= pins_raw; // RL21
      sync2_q <= sync1_q; // RL21 RL18
      prev_q <= sync2_q;
    end
  end

  // ************************************************************
  // Event detection
  // ************************************************************
  logic [3:0] ext_edge;          // Valid ext edges
  logic [3:0] pol;               // Polarity per pin
  logic pc_event;                // Port change event
  logic cnt_edge;                // Counter pin edge
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ext
      assign pol[g] = second_q[EITZ_SEC_POL0 - g];
      // Rising when polarity 1, falling when 0
      assign ext_edge[g] = pol[g] ? (sync2_q.ext[g] & ~prev_q.ext[g]) :
                                    (~sync2_q.ext[g] & prev_q.ext[g]); // RL1
    end
  endgenerate
  // Enabled pins that differ from last cycle
  assign pc_event = |((sync2_q.port ^ prev_q.port) & pce_q[7:4]); // RL22 RL11 RL14
  // Rising when edge select 0, falling when 1
  assign cnt_edge = tctl_q[EITZ_TCTL_EDGE] ? (~sync2_q.cnt & prev_q.cnt) :
                                             (sync2_q.cnt & ~prev_q.cnt); // RL17

  // ************************************************************
  // Timer zero
  // ************************************************************
  logic tick;                    // Count enable this cycle
  logic ovf;                     // Overflow this cycle
  logic is8;                     // 8-bit mode
  assign is8 = tctl_q[EITZ_TCTL_8BIT];
  assign tick = tctl_q[EITZ_TCTL_ON] & (inhibit_q == 4'h0) & ~wr_low &
                (tctl_q[EITZ_TCTL_SRC] ? cnt_edge : 1'b1); // RL15 RL17 RL16
  assign ovf = tick & (is8 ? (count_q[7:0] == 8'hff) : (count_q == 16'hffff)); // RL8 RL9

  // Count, with buffered high byte writes
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      count_q <= 16'h0000;
    end else if (wr_low) begin
      // High byte from buffer at the same moment in 16-bit mode
      count_q <= {is8 ? count_q[15:8] : high_buf_q, PWDATA_I[7:0]}; // RL20
    end else if (tick) begin
      if (is8) begin
        count_q <= {count_q[15:8], 8'(count_q[7:0] + 8'h01)}; // RL8
      end else begin
        count_q <= 16'(count_q + 16'h0001); // RL9
      end
    end
  end

  // Inhibit counter after a count write
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      inhibit_q <= 4'h0;
    end else if (wr_low) begin
      inhibit_q <= EITZ_WR_INHIBIT_CLKS; // RL16
    end else if (inhibit_q != 4'h0) begin
      inhibit_q <= 4'(inhibit_q - 4'h1);
    end
  end

  // High buffer: written by software, loaded on low reads in 16-bit mode
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      high_buf_q <= 8'h00;
    end else if (rd_low & ~is8) begin
      high_buf_q <= count_q[15:8]; // RL19
    end else if (wr & hit(PADDR_I, EITZ_ADDR_THIGH)) begin
      high_buf_q <= PWDATA_I[7:0];
    end
  end

  // ************************************************************
  // Control registers and flags (set wins over clear)
  // ************************************************************
  logic [7:0] main_d;            // Next main control
  logic [7:0] third_d;           // Next third control
  always_comb begin
    main_d = wr_main ? PWDATA_I[7:0] : main_q;
    third_d = wr_third ? PWDATA_I[7:0] : third_q;
    main_d[EITZ_MAIN_TOIF] = main_d[EITZ_MAIN_TOIF] | ovf;
    main_d[EITZ_MAIN_E0IF] = main_d[EITZ_MAIN_E0IF] | ext_edge[0]; // RL2
    main_d[EITZ_MAIN_PCIF] = main_d[EITZ_MAIN_PCIF] | pc_event; // RL11
    third_d[EITZ_THR_IF1 +: 3] = third_d[EITZ_THR_IF1 +: 3] | ext_edge[3:1]; // RL2
    third_d[5:3] = third_d[5:3];
  end

  // Main and third control
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      main_q <= EITZ_RST_MAIN;
      third_q <= EITZ_RST_THIRD;
    end else begin
      main_q <= main_d;
      third_q <= third_d;
    end
  end

  // Plain software registers
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      second_q <= EITZ_RST_SECOND;
      pce_q <= EITZ_RST_PCE;
      tctl_q <= EITZ_RST_TCTL;
    end else if (wr) begin
      if (hit(PADDR_I, EITZ_ADDR_SECOND)) begin
        second_q <= PWDATA_I[7:0];
      end
      if (hit(PADDR_I, EITZ_ADDR_PCE)) begin
        pce_q <= PWDATA_I[7:0] & EITZ_PCE_MASK; // RL14
      end
      if (hit(PADDR_I, EITZ_ADDR_TCTL)) begin
        tctl_q <= PWDATA_I[7:0];
      end
    end
  end

  // ************************************************************
  // Interrupt requests and priority
  // ************************************************************
  logic [3:0] ext_en;            // Ext enables
  logic [3:0] ext_flag;          // Ext flags
  logic [3:0] ext_pri;           // Ext priorities
  logic [3:0] ext_req;           // Ext requests
  logic to_req, pc_req;          // Timer and port requests
  logic hi_any, lo_any;          // Per level requests
  assign ext_en = {third_q[5:3], main_q[EITZ_MAIN_E0IE]};
  assign ext_flag = {third_q[2:0], main_q[EITZ_MAIN_E0IF]};
  assign ext_pri = {second_q[EITZ_SEC_E3IP], third_q[EITZ_THR_E2IP],
                    third_q[EITZ_THR_E1IP], 1'b1}; // RL6 RL7
  assign ext_req = ext_en & ext_flag; // RL2 RL3
  assign to_req = main_q[EITZ_MAIN_TOIE] & main_q[EITZ_MAIN_TOIF]; // RL10
  assign pc_req = main_q[EITZ_MAIN_PCIE] & main_q[EITZ_MAIN_PCIF]; // RL12
  assign hi_any = |(ext_req & ext_pri) | (to_req & second_q[EITZ_SEC_TOIP]) |
                  (pc_req & second_q[EITZ_SEC_PCIP]); // RL10 RL13
  assign lo_any = |(ext_req & ~ext_pri) | (to_req & ~second_q[EITZ_SEC_TOIP]) |
                  (pc_req & ~second_q[EITZ_SEC_PCIP]);
  // Vector only when global enable is set
  assign IRQ_HIGH_O = main_q[EITZ_MAIN_GIE] & hi_any & ~sleep_q; // RL5
  assign IRQ_LOW_O = main_q[EITZ_MAIN_GIE] & lo_any & ~sleep_q; // RL5
  assign WAKE_O = wake_q;

  // ************************************************************
  // Power managed mode and wake
  // ************************************************************
  // Sleep entered by writing bit 0; ext flag with pre-set enable wakes
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sleep_q <= 1'b0;
      wake_en_q <= 4'h0;
      wake_q <= 1'b0;
    end else begin
      wake_q <= 1'b0;
      if (sleep_q && (|(wake_en_q & ext_flag))) begin
        sleep_q <= 1'b0; // RL4
        wake_q <= 1'b1;
      end else if (wr & hit(PADDR_I, EITZ_ADDR_PWR) & PWDATA_I[0] & ~sleep_q) begin
        sleep_q <= 1'b1;
        wake_en_q <= ext_en; // RL4
      end
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  logic [7:0] rd_byte;           // Selected byte
  always_comb begin
    rd_byte = 8'h00;
    case (PADDR_I)
      EITZ_ADDR_MAIN: rd_byte = main_q;
      EITZ_ADDR_SECOND: rd_byte = second_q;
      EITZ_ADDR_THIRD: rd_byte = third_q;
      EITZ_ADDR_PCE: rd_byte = pce_q & EITZ_PCE_MASK; // RL14
      EITZ_ADDR_TCTL: rd_byte = tctl_q;
      EITZ_ADDR_TLOW: rd_byte = count_q[7:0];
      EITZ_ADDR_THIGH: rd_byte = high_buf_q; // RL19
      EITZ_ADDR_PWR: rd_byte = {7'h00, sleep_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // Registered read data, captured in setup phase
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prdata_q <= 32'h00000000;
    end else if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
      prdata_q <= {24'h000000, rd_byte};
    end
  end

endmodule
`default_nettype wire

// file: sim/eitz_pins_model.sv
// Pin-side model: external irq pins, port b pins and counter clock
`timescale 1ns/10ps
`default_nettype none
module eitz_pins_model
  import eitz_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Pins toward the block
  output var eitz_pins_type pins_o
);
  // Quiet levels before any scenario runs
  initial pins_o = '0;
  // Ext irq pins change just after an edge
  task automatic set_ext(input logic [3:0] v);
    @(posedge clk_i);
    pins_o.ext <= v;
  endtask
  // Port pins 7..4 change just after an edge
  task automatic set_port(input logic [3:0] v);
    @(posedge clk_i);
    pins_o.port <= v;
  endtask
  // Slow pulses so each level survives the synchroniser
  task automatic cnt_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      pins_o.cnt <= 1'b1;
      repeat (4) @(posedge clk_i);
      pins_o.cnt <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: sim/eitz_top_sva.sv
// Checker: bus answer, read data shape and wake pulse at the top ports
`timescale 1ns/10ps
`default_nettype none
module eitz_top_sva
  import eitz_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Pins and processor side
  input wire logic [3:0] EXT_IRQ_PIN_I,
  input wire logic [3:0] PORT_B_PINS_I,
  input wire logic COUNTER_CLOCK_PIN_I,
  input wire logic IRQ_HIGH_O,
  input wire logic IRQ_LOW_O,
  input wire logic WAKE_O
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  // Zero wait states
  property p_ready; PREADY_O; endproperty
  // Access above the power register address is refused
  property p_err_map; PSEL_I && PENABLE_I && PADDR_I > EITZ_ADDR_PWR |-> PSLVERR_O; endproperty
  property p_err_phase; PSLVERR_O |-> PSEL_I && PENABLE_I; endproperty
  property p_err_data; PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0; endproperty
  // Upper read bits always zero
  property p_rd_upper; PSEL_I && PENABLE_I && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0; endproperty
  // Pin enable low nibble reads zero
  property p_pce_low;
    PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == EITZ_ADDR_PCE |-> PRDATA_O[3:0] == 4'h0;
  endproperty
  // Power register holds one bit only
  property p_pwr_upper;
    PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == EITZ_ADDR_PWR |-> PRDATA_O[7:1] == 7'h0;
  endproperty
  // Wake is a single cycle pulse
  property p_wake_pulse; $rose(WAKE_O) |=> !WAKE_O ##1 !WAKE_O; endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  a_err_map: assert property (p_err_map) else $error("unmapped not refused");
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  a_err_data: assert property (p_err_data) else $error("refused read not zero");
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  a_pce_low: assert property (p_pce_low) else $error("pin enable low bits set");
  a_pwr_upper: assert property (p_pwr_upper) else $error("power upper bits set");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
  // Main scenarios reached
  c_err: cover property (PSLVERR_O);
  c_wake: cover property (WAKE_O);
  c_irq_hi: cover property (IRQ_HIGH_O);
  c_irq_lo: cover property (IRQ_LOW_O);
endmodule
bind eitz_top eitz_top_sva u_sva (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .EXT_IRQ_PIN_I(EXT_IRQ_PIN_I), .PORT_B_PINS_I(PORT_B_PINS_I),
  .COUNTER_CLOCK_PIN_I(COUNTER_CLOCK_PIN_I), .IRQ_HIGH_O(IRQ_HIGH_O), .IRQ_LOW_O(IRQ_LOW_O),
  .WAKE_O(WAKE_O));
`default_nettype wire

// file: sim/eitz_top_tb.sv
// Testbench: registers, edge and port interrupts, timer and wake
`timescale 1ns/10ps
`default_nettype none
module eitz_top_tb
  import eitz_pkg::*;
;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq_hi, irq_lo, wake, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  eitz_pins_type pins;
  int fail_count, checks_done;
  // Pin-side partner
  eitz_pins_model u_pins (.clk_i(clk), .pins_o(pins));
  eitz_top uut (.CLK_SYS_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_IRQ_PIN_I(pins.ext),
    .PORT_B_PINS_I(pins.port), .COUNTER_CLOCK_PIN_I(pins.cnt), .IRQ_HIGH_O(irq_hi),
    .IRQ_LOW_O(irq_lo), .WAKE_O(wake));
  // ************************************************************
  // Helpers
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer, waits for ready
  task automatic apb(input logic is_wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= is_wr;
    paddr <= a;
    // Upper data bits carry a varying pattern the block must ignore
    pwdata <= {~{3{d}}, d};
    @(posedge clk);
    penable <= 1'b1;
    repeat (16) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string name);
    apb(1'b0, a, 8'h00);
    chk(name, rd_q, {24'h0, e});
  endtask
  // Irq outputs once settled
  task automatic irqc(input logic [1:0] e);
    @(negedge clk);
    chk("irq high/low", {30'h0, irq_hi, irq_lo}, {30'h0, e});
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs;
    rdc(EITZ_ADDR_MAIN, EITZ_RST_MAIN, "main reset");
    rdc(EITZ_ADDR_SECOND, EITZ_RST_SECOND, "second reset");
    rdc(EITZ_ADDR_THIRD, EITZ_RST_THIRD, "third reset");
    rdc(EITZ_ADDR_TCTL, EITZ_RST_TCTL, "timer ctl reset");
    rdc(EITZ_ADDR_PCE, EITZ_RST_PCE, "pin enable reset");
    rdc(12'h020, 8'h00, "unmapped data");
    chk("unmapped error", {31'h0, err_q}, 32'h1);
    wr(EITZ_ADDR_PCE, 8'hff);
    rdc(EITZ_ADDR_PCE, 8'hf0, "pin enable mask");
  endtask
  task automatic t_ext;
    u_pins.set_ext(4'hf);
    repeat (6) @(posedge clk);
    rdc(EITZ_ADDR_MAIN, 8'h02, "rise flag zero");
    rdc(EITZ_ADDR_THIRD, 8'hc7, "rise flags");
    wr(EITZ_ADDR_MAIN, 8'h00);
    wr(EITZ_ADDR_THIRD, 8'hc0);
    wr(EITZ_ADDR_SECOND, 8'h07);
    u_pins.set_ext(4'h0);
    repeat (6) @(posedge clk);
    rdc(EITZ_ADDR_THIRD, 8'hc7, "fall flags");
    wr(EITZ_ADDR_THIRD, 8'h0f);
    wr(EITZ_ADDR_MAIN, 8'h82);
    irqc(2'b01);
    wr(EITZ_ADDR_THIRD, 8'h4f);
    irqc(2'b10);
    wr(EITZ_ADDR_THIRD, 8'h07);
    wr(EITZ_ADDR_MAIN, 8'h92);
    irqc(2'b10);
    wr(EITZ_ADDR_MAIN, 8'h82);
    irqc(2'b00);
    wr(EITZ_ADDR_MAIN, 8'h00);
    wr(EITZ_ADDR_THIRD, 8'hc0);
  endtask
  task automatic t_timer;
    wr(EITZ_ADDR_TCTL, 8'hc0);
    wr(EITZ_ADDR_TLOW, 8'hf0);
    rdc(EITZ_ADDR_TLOW, 8'hf0, "count held");
    rdc(EITZ_ADDR_MAIN, 8'h00, "no early overflow");
    repeat (40) @(posedge clk);
    rdc(EITZ_ADDR_MAIN, 8'h04, "8-bit overflow");
    wr(EITZ_ADDR_MAIN, 8'ha4);
    irqc(2'b10);
    wr(EITZ_ADDR_SECOND, 8'h03);
    irqc(2'b01);
    wr(EITZ_ADDR_TCTL, 8'h80);
    wr(EITZ_ADDR_MAIN, 8'h00);
    wr(EITZ_ADDR_THIGH, 8'hfe);
    wr(EITZ_ADDR_TLOW, 8'hf0);
    rdc(EITZ_ADDR_TLOW, 8'hf0, "16-bit low");
    rdc(EITZ_ADDR_THIGH, 8'hfe, "16-bit high");
    repeat (60) @(posedge clk);
    rdc(EITZ_ADDR_MAIN, 8'h00, "low wrap only");
    // Low read after the low wrap latches the new true high byte
    apb(1'b0, EITZ_ADDR_TLOW, 8'h00);
    rdc(EITZ_ADDR_THIGH, 8'hff, "high after low read");
    repeat (260) @(posedge clk);
    rdc(EITZ_ADDR_MAIN, 8'h04, "16-bit overflow");
  endtask
  task automatic t_counter;
    wr(EITZ_ADDR_TCTL, 8'hf0);
    wr(EITZ_ADDR_TLOW, 8'h00);
    repeat (10) @(posedge clk);
    u_pins.cnt_pulses(5);
    repeat (6) @(posedge clk);
    rdc(EITZ_ADDR_TLOW, 8'h05, "falling count");
    wr(EITZ_ADDR_TCTL, 8'he0);
    u_pins.cnt_pulses(3);
    repeat (6) @(posedge clk);
    rdc(EITZ_ADDR_TLOW, 8'h08, "rising count");
  endtask
  task automatic t_port;
    wr(EITZ_ADDR_PCE, 8'h10);
    wr(EITZ_ADDR_MAIN, 8'h00);
    u_pins.set_port(4'h2);
    repeat (6) @(posedge clk);
    rdc(EITZ_ADDR_MAIN, 8'h00, "disabled pin");
    u_pins.set_port(4'h3);
    repeat (6) @(posedge clk);
    rdc(EITZ_ADDR_MAIN, 8'h01, "change flag");
    wr(EITZ_ADDR_MAIN, 8'h89);
    irqc(2'b10);
    wr(EITZ_ADDR_SECOND, 8'h02);
    irqc(2'b01);
    // Upper two port pins: only pin 7 enabled
    wr(EITZ_ADDR_PCE, 8'h80);
    wr(EITZ_ADDR_MAIN, 8'h00);
    u_pins.set_port(4'h7);
    repeat (6) @(posedge clk);
    rdc(EITZ_ADDR_MAIN, 8'h00, "pin six disabled");
    u_pins.set_port(4'hf);
    repeat (6) @(posedge clk);
    rdc(EITZ_ADDR_MAIN, 8'h01, "pin seven change");
    wr(EITZ_ADDR_MAIN, 8'h00);
  endtask
  task automatic t_wake;
    logic seen;
    seen = 1'b0;
    wr(EITZ_ADDR_MAIN, 8'h10);
    wr(EITZ_ADDR_PWR, 8'h01);
    rdc(EITZ_ADDR_PWR, 8'h01, "sleeping");
    u_pins.set_ext(4'h1);
    u_pins.set_ext(4'h0);
    repeat (20) begin
      @(negedge clk);
      if (wake === 1'b1) seen = 1'b1;
    end
    chk("wake pulse", {31'h0, seen}, 32'h1);
    irqc(2'b00);
    wr(EITZ_ADDR_MAIN, 8'h92);
    irqc(2'b10);
  endtask
  // Mid-run reset returns the registers to their reset values
  task automatic t_reset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdc(EITZ_ADDR_MAIN, EITZ_RST_MAIN, "main after reset");
    rdc(EITZ_ADDR_PCE, EITZ_RST_PCE, "pin enable after reset");
    rdc(EITZ_ADDR_TCTL, EITZ_RST_TCTL, "timer ctl after reset");
    irqc(2'b00);
  endtask
  // ************************************************************
  // Verdict and main sequence
  // ************************************************************
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog well above the run length
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_ext();
    t_timer();
    t_counter();
    t_port();
    t_wake();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
